//--- act_pkg.sv
// Constants, encodings and state types for the converter compare and trigger delay block
package act_pkg;
   // =====================================================
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RES_W = 12;
   localparam int DLY_W = 9;
   localparam int SEL_W = 2;
   localparam int INT_W = 2;
   localparam int ADC_CLK_DIV_DEF = 4;

   // =====================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CMP_CTRL = 8'hE2;
   localparam logic [ADDR_W-1:0] OFS_DLY_LOW = 8'hE3;
   localparam logic [ADDR_W-1:0] OFS_TRIG_CTRL = 8'hF0;
   localparam logic [ADDR_W-1:0] OFS_CONV_CTRL = 8'hF1;
   localparam logic [ADDR_W-1:0] OFS_THR_LOW = 8'hF2;
   localparam logic [ADDR_W-1:0] OFS_THR_HIGH = 8'hF3;
   localparam logic [ADDR_W-1:0] OFS_RES_LOW = 8'hF4;
   localparam logic [ADDR_W-1:0] OFS_RES_HIGH = 8'hF5;
   localparam logic [ADDR_W-1:0] OFS_PWM_RUN = 8'hF6;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'hF7;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'hF8;

   // =====================================================
   // Field positions and write masks
   localparam int CMP_BRAKE_EN = 7;
   localparam int CMP_POLARITY = 6;
   localparam int CMP_ENABLE = 5;
   localparam int CMP_RESULT = 4;
   localparam int CMP_DLY_MSB = 0;
   localparam logic [DATA_W-1:0] CMP_WR_MASK = 8'hE1;
   localparam int TRIG_EXT_EN = 1;
   localparam int TRIG_TYPE_LSB = 2;
   localparam int TRIG_SRC_LSB = 4;
   localparam logic [DATA_W-1:0] TRIG_WR_MASK = 8'h3E;
   localparam int CONV_START = 6;
   localparam int CONV_DONE = 7;
   localparam int PWM_RUN_BIT = 0;
   localparam int INT_DONE = 0;
   localparam int INT_BRAKE = 1;

   // =====================================================
   // Reset values
   localparam logic [DATA_W-1:0] RST_REG8 = 8'h00;
   localparam logic [RES_W-1:0] RST_WORD = 12'h000;
   localparam logic [INT_W-1:0] RST_INT = 2'h0;

   // =====================================================
   // Trigger encodings
   localparam logic [SEL_W-1:0] TT_FALL = 2'h0;
   localparam logic [SEL_W-1:0] TT_RISE = 2'h1;
   localparam logic [SEL_W-1:0] TT_CENTRE = 2'h2;
   localparam logic [SEL_W-1:0] TS_PWM0 = 2'h0;
   localparam logic [SEL_W-1:0] TS_PWM2 = 2'h1;
   localparam logic [SEL_W-1:0] TS_PWM4 = 2'h2;

   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_CONV = 1'b1} act_conv_state_t;
   typedef enum logic [0:0] {DLY_IDLE = 1'b0, DLY_WAIT = 1'b1} act_dly_state_t;
endpackage

//--- act_trigger_delay.sv
// External trigger selection, edge detection and start delay counter
`timescale 1ns/1ps
module act_trigger_delay #(
   parameter int DLY_W = act_pkg::DLY_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic adcTick,
   input wire logic extEnable,
   input wire logic [act_pkg::SEL_W-1:0] trigType,
   input wire logic [act_pkg::SEL_W-1:0] trigSource,
   input wire logic [2:0] pwmChannel,
   input wire logic pwmCentre,
   input wire logic pwmEnd,
   input wire logic startPin,
   input wire logic busy,
   input wire logic [DLY_W-1:0] delayValue,
   output logic fire
);
   import act_pkg::*;

   typedef struct packed {
      act_dly_state_t state;
      logic pinMeta;
      logic pinSync;
      logic lastLevel;
      logic [DLY_W-1:0] count;
      logic fire;
   } act_dly_t;

   act_dly_t s;
   act_dly_t next_s;
   logic level;
   logic hit;

   // =====================================================
   // Source and condition select
   always_comb begin
      case (trigSource)
         TS_PWM0: level = pwmChannel[0];
         TS_PWM2: level = pwmChannel[1];
         TS_PWM4: level = pwmChannel[2];
         default: level = s.pinSync;
      endcase
      case (trigType)
         TT_FALL: hit = s.lastLevel & ~level;
         TT_RISE: hit = ~s.lastLevel & level;
         TT_CENTRE: hit = pwmCentre;
         default: hit = pwmEnd;
      endcase
   end

   // =====================================================
   // Delay counter
   always_comb begin
      next_s = s;
      next_s.pinMeta = startPin;
      next_s.pinSync = s.pinMeta;
      next_s.lastLevel = level;
      next_s.fire = 1'b0;
      case (s.state)
         DLY_IDLE: begin
            // Busy converter drops the trigger
            if (extEnable && !busy && hit) begin
               next_s.state = DLY_WAIT;
               next_s.count = delayValue;
            end
         end
         DLY_WAIT: begin
            // Further triggers are not looked at while waiting
            if (!extEnable) begin
               next_s.state = DLY_IDLE;
            end else if (adcTick) begin
               if (s.count == '0) begin
                  next_s.fire = 1'b1;
                  next_s.state = DLY_IDLE;
               end else begin
                  next_s.count = s.count - 1'b1;
               end
            end
         end
         default: next_s.state = DLY_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign fire = s.fire;

   // =====================================================
   // Checks
   AST_DLY_NEEDS_EXT: assert property (@(posedge clk) disable iff (reset)
      !extEnable |=> !fire) else $error("trigger fired with external start off");
   AST_DLY_NO_RESTART: assert property (@(posedge clk) disable iff (reset)
      (s.state == DLY_WAIT && extEnable && !adcTick) |=> s.count == $past(s.count))
      else $error("pending delay count disturbed");
   AST_DLY_COUNTDOWN: assert property (@(posedge clk) disable iff (reset)
      (s.state == DLY_WAIT && extEnable && adcTick && s.count != '0) |=> s.count == $past(s.count) - 1'b1)
      else $error("pending delay did not count down");
endmodule

//--- act_compare_trigger.sv
// Converter control: result compare, fault brake, trigger delay and registers
`timescale 1ns/1ps
module act_compare_trigger #(
   parameter int ADC_CLK_DIV = act_pkg::ADC_CLK_DIV_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [act_pkg::ADDR_W-1:0] address,
   input wire logic [act_pkg::DATA_W-1:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [act_pkg::DATA_W-1:0] rdData,
   input wire logic [2:0] pwmChannel,
   input wire logic pwmCentre,
   input wire logic pwmEnd,
   input wire logic externalStartPin,
   output logic convStart,
   input wire logic convDone,
   input wire logic [act_pkg::RES_W-1:0] convData,
   output logic faultBrake,
   output logic pwm_run_a,
   output logic irq
);
   import act_pkg::*;

   localparam int DIV_W = $clog2(ADC_CLK_DIV) + 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ADC_CLK_DIV - 1);

   typedef struct packed {
      act_conv_state_t fsm;
      logic [DIV_W-1:0] divCount;
      logic [DATA_W-1:0] cmpCtrl;
      logic [DATA_W-1:0] dlyLow;
      logic [DATA_W-1:0] trigCtrl;
      logic [RES_W-1:0] threshold;
      logic [RES_W-1:0] result;
      logic pwm_run_a;
      logic [INT_W-1:0] intStatus;
      logic [INT_W-1:0] intMask;
      logic convStart;
      logic faultBrake;
      logic [DATA_W-1:0] rdData;
   } act_main_t;

   act_main_t s;
   act_main_t next_s;
   logic adcTick;
   logic fire;
   logic swStart;
   logic cmpNow;
   logic finishing;
   logic brakeCause;
   logic cmpResult;
   logic [RES_W-1:0] threshold;
   logic [INT_W-1:0] events;

   assign adcTick = (s.divCount == '0);
   assign cmpResult = s.cmpCtrl[CMP_RESULT];
   assign threshold = s.threshold;
   assign finishing = (s.fsm == ST_CONV) && convDone;
   assign swStart = wrEn && (address == OFS_CONV_CTRL) && wrData[CONV_START];

   // =====================================================
   // Comparator
   always_comb begin
      if (s.cmpCtrl[CMP_POLARITY]) begin
         cmpNow = (convData < s.threshold);
      end else begin
         cmpNow = (convData >= s.threshold);
      end
   end

   assign brakeCause = finishing && s.cmpCtrl[CMP_ENABLE] && s.cmpCtrl[CMP_BRAKE_EN] && cmpNow;

   // =====================================================
   // Trigger and delay
   act_trigger_delay #(
      .DLY_W(DLY_W)
   ) u_delay (
      .clk(clk),
      .reset(reset),
      .adcTick(adcTick),
      .extEnable(s.trigCtrl[TRIG_EXT_EN]),
      .trigType(s.trigCtrl[TRIG_TYPE_LSB +: SEL_W]),
      .trigSource(s.trigCtrl[TRIG_SRC_LSB +: SEL_W]),
      .pwmChannel(pwmChannel),
      .pwmCentre(pwmCentre),
      .pwmEnd(pwmEnd),
      .startPin(externalStartPin),
      .busy(s.fsm == ST_CONV),
      .delayValue({s.cmpCtrl[CMP_DLY_MSB], s.dlyLow}),
      .fire(fire)
   );

   // =====================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.convStart = 1'b0;
      next_s.faultBrake = 1'b0;
      next_s.rdData = RST_REG8;
      events = '0;
      next_s.divCount = adcTick ? DIV_LAST : s.divCount - 1'b1;

      if (wrEn) begin
         case (address)
            OFS_CMP_CTRL: begin
               // Result bit keeps its own value
               next_s.cmpCtrl = (wrData & CMP_WR_MASK) | (s.cmpCtrl & ~CMP_WR_MASK);
            end
            OFS_DLY_LOW: next_s.dlyLow = wrData;
            OFS_TRIG_CTRL: next_s.trigCtrl = wrData & TRIG_WR_MASK;
            OFS_THR_LOW: next_s.threshold[7:0] = wrData;
            OFS_THR_HIGH: next_s.threshold[RES_W-1:8] = wrData[RES_W-9:0];
            OFS_PWM_RUN: next_s.pwm_run_a = wrData[PWM_RUN_BIT];
            OFS_INT_STAT: next_s.intStatus = s.intStatus & ~wrData[INT_W-1:0];
            OFS_INT_MASK: next_s.intMask = wrData[INT_W-1:0];
            default: next_s.intMask = s.intMask;
         endcase
      end

      case (s.fsm)
         ST_IDLE: begin
            // Software start is never delayed
            if (swStart || fire) begin
               next_s.fsm = ST_CONV;
               next_s.convStart = 1'b1;
            end
         end
         ST_CONV: begin
            if (convDone) begin
               next_s.fsm = ST_IDLE;
               next_s.result = convData;
               events[INT_DONE] = 1'b1;
               if (s.cmpCtrl[CMP_ENABLE]) begin
                  next_s.cmpCtrl[CMP_RESULT] = cmpNow;
               end
               if (brakeCause) begin
                  next_s.faultBrake = 1'b1;
                  // Hardware clear beats a same-cycle software set
                  next_s.pwm_run_a = 1'b0;
                  events[INT_BRAKE] = 1'b1;
               end
            end
         end
         default: next_s.fsm = ST_IDLE;
      endcase

      // Set after clear so a new event is never lost
      next_s.intStatus = next_s.intStatus | events;

      if (rdEn) begin
         case (address)
            OFS_CMP_CTRL: next_s.rdData = s.cmpCtrl;
            OFS_DLY_LOW: next_s.rdData = s.dlyLow;
            OFS_TRIG_CTRL: next_s.rdData = s.trigCtrl;
            OFS_CONV_CTRL: begin
               next_s.rdData[CONV_START] = (s.fsm == ST_CONV);
               next_s.rdData[CONV_DONE] = s.intStatus[INT_DONE];
            end
            OFS_THR_LOW: next_s.rdData = s.threshold[7:0];
            OFS_THR_HIGH: next_s.rdData[RES_W-9:0] = s.threshold[RES_W-1:8];
            OFS_RES_LOW: next_s.rdData = s.result[7:0];
            OFS_RES_HIGH: next_s.rdData[RES_W-9:0] = s.result[RES_W-1:8];
            OFS_PWM_RUN: next_s.rdData[PWM_RUN_BIT] = s.pwm_run_a;
            OFS_INT_STAT: next_s.rdData[INT_W-1:0] = s.intStatus;
            OFS_INT_MASK: next_s.rdData[INT_W-1:0] = s.intMask;
            default: next_s.rdData = RST_REG8;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdData = s.rdData;
   assign convStart = s.convStart;
   assign faultBrake = s.faultBrake;
   assign pwm_run_a = s.pwm_run_a;
   assign irq = |(s.intStatus & s.intMask);

   // =====================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   AST_BRAKE_CAUSE: assert property (
      faultBrake |-> $past(brakeCause)) else $error("fault brake without enabled compare hit");
   AST_BRAKE_DISABLED: assert property (
      (finishing && !s.cmpCtrl[CMP_BRAKE_EN]) |=> !faultBrake) else $error("brake asserted while disabled");
   AST_RUN_CLEARED: assert property (
      faultBrake |-> !pwm_run_a) else $error("run bit survived fault brake");
   AST_RUN_STAYS_OFF: assert property (
      (!pwm_run_a && !(wrEn && address == OFS_PWM_RUN)) |=> !pwm_run_a) else $error("run bit set without software");
   AST_POLARITY: assert property (
      (finishing && s.cmpCtrl[CMP_ENABLE] && !s.cmpCtrl[CMP_POLARITY])
      |=> cmpResult == ($past(convData) >= $past(threshold))) else $error("compare result wrong for polarity 0");
   AST_CMP_OFF: assert property (
      (finishing && !s.cmpCtrl[CMP_ENABLE]) |=> $stable(cmpResult)) else $error("disabled comparator changed result");
   AST_RESULT_RO: assert property (
      (!finishing) |=> $stable(cmpResult)) else $error("compare result changed outside completion");
   AST_BUSY_CLEAR: assert property (
      finishing |=> s.fsm == ST_IDLE) else $error("busy not cleared");
   AST_IGNORE_BUSY: assert property (
      (s.fsm == ST_CONV && !convDone) |=> !convStart) else $error("start issued while busy");
   AST_SW_NO_DELAY: assert property (
      (swStart && s.fsm == ST_IDLE) |=> convStart ##1 !convStart) else $error("software start delayed");
   AST_BRAKE_PULSE: assert property (
      faultBrake |=> !faultBrake) else $error("brake request longer than one cycle");


   // =====================================================
   // Compare and brake checks
   AST_POLARITY_LOW: assert property (
      (finishing && s.cmpCtrl[CMP_ENABLE] && s.cmpCtrl[CMP_POLARITY])
      |=> cmpResult == ($past(convData) < $past(threshold))) else $error("compare result wrong for polarity 1");

   AST_BRAKE_HIT: assert property (
      brakeCause |=> faultBrake && !pwm_run_a) else $error("enabled compare hit gave no brake");

   AST_BRAKE_STATUS: assert property (
      faultBrake |-> s.intStatus[INT_BRAKE]) else $error("brake status not set");

   AST_RUN_SW_SET: assert property (
      (wrEn && address == OFS_PWM_RUN && wrData[PWM_RUN_BIT] && !brakeCause) |=> pwm_run_a)
      else $error("software could not set run bit");

   AST_THR_WRITE: assert property (
      (wrEn && address == OFS_THR_LOW) |=> threshold[7:0] == $past(wrData))
      else $error("threshold low byte not written");

   // =====================================================
   // Start, delay and busy checks
   AST_DLY_MSB: assert property (
      (wrEn && address == OFS_CMP_CTRL) |=> s.cmpCtrl[CMP_DLY_MSB] == $past(wrData[CMP_DLY_MSB]))
      else $error("delay top bit not written");

   AST_DIV_TICK: assert property (
      adcTick |=> s.divCount == DIV_LAST) else $error("converter clock divider not reloaded");

   AST_TRIG_START: assert property (
      (fire && s.fsm == ST_IDLE) |=> convStart) else $error("expired delay did not start conversion");

   AST_START_FROM_IDLE: assert property (
      convStart |-> $past(s.fsm == ST_IDLE)) else $error("start issued from busy state");

   AST_BUSY_SET: assert property (
      convStart |-> s.fsm == ST_CONV) else $error("busy not set with start");

   AST_START_PULSE: assert property (
      convStart |=> !convStart) else $error("start request longer than one cycle");

   AST_BUSY_READ: assert property (
      (rdEn && address == OFS_CONV_CTRL) |=> rdData[CONV_START] == $past(s.fsm == ST_CONV))
      else $error("start bit read back wrong");

   // =====================================================
   // Completion and bus checks
   AST_RESULT_STORE: assert property (
      finishing |=> s.result == $past(convData)) else $error("result not stored at completion");

   AST_DONE_SET: assert property (
      finishing |=> s.intStatus[INT_DONE]) else $error("done status lost at completion");

   AST_DONE_CLEAR: assert property (
      (wrEn && address == OFS_INT_STAT && wrData[INT_DONE] && !finishing) |=> !s.intStatus[INT_DONE])
      else $error("done status not cleared by write");

   AST_READ_IDLE: assert property (
      !rdEn |=> rdData == '0) else $error("read data not zero outside read");

   COV_BRAKE: cover property (faultBrake);
   COV_SW_CONV: cover property (swStart && s.fsm == ST_IDLE ##1 convStart ##[1:50] finishing);
   COV_TRIG_CONV: cover property (fire && s.fsm == ST_IDLE ##1 convStart);
   COV_IRQ: cover property (irq);
   COV_RUN_RESTART: cover property (!pwm_run_a ##1 pwm_run_a);
endmodule

//--- act_converter_model.sv
// Behavioural converter: answers each start pulse received while idle with a result after a fixed latency
`timescale 1ns/1ps
module act_converter_model
   import act_pkg::*;
#(
   parameter int LAT = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic convStart,
   input wire logic [act_pkg::RES_W-1:0] nextResult,
   output logic convDone,
   output logic [act_pkg::RES_W-1:0] convData
);
   int count;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= 0;
         convDone <= 1'h0;
         convData <= 12'h000;
      end else begin
         convDone <= (count == 1);
         // Junk outside the done cycle, so a stale result is never mistaken for valid
         convData <= (count == 1) ? nextResult : ~convData;
         if (convStart && count == 0)
            count <= LAT;
         else if (count > 0)
            count <= count - 1;
      end
   end
endmodule

//--- act_compare_trigger_test.sv
// Self-checking bench for the converter compare and trigger delay block
`timescale 1ns/1ps
module act_compare_trigger_test;
   import act_pkg::*;
   logic clk = 1'h0, reset = 1'h1, wrEn = 1'h0, rdEn = 1'h0, pin = 1'h0;
   logic pwmCentre = 1'h0, pwmEnd = 1'h0, convStart, convDone, faultBrake, pwm_run_a, irq, pol;
   logic [7:0] address = 8'h00, wrData = 8'h00, rdData, r;
   logic [2:0] pwmChannel = 3'h0;
   logic [11:0] convData, nextResult = 12'h000, thr, v;
   logic [3:0] lv;
   logic [7:0] cfg [5] = '{8'h06, 8'h12, 8'h26, 8'h36, 8'h0E};
   int numErrors = 0, nChecks = 0, seed = 23, starts = 0, brakes = 0, b, s, n0, n1;

   // Converter clock equal to the system clock keeps delay counts exact
   act_compare_trigger #(.ADC_CLK_DIV(1)) act_compare_trigger_i (.clk(clk), .reset(reset), .address(address),
      .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .pwmChannel(pwmChannel), .pwmCentre(pwmCentre),
      .pwmEnd(pwmEnd), .externalStartPin(pin), .convStart(convStart), .convDone(convDone), .convData(convData),
      .faultBrake(faultBrake), .pwm_run_a(pwm_run_a), .irq(irq));
   act_converter_model #(.LAT(8)) act_converter_model_i (.clk(clk), .reset(reset), .convStart(convStart),
      .nextResult(nextResult), .convDone(convDone), .convData(convData));

   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      starts <= starts + int'(convStart);
      brakes <= brakes + int'(faultBrake);
   end

   // =====================================================
   // Helpers
   function automatic logic cmpExp(input logic [11:0] res, input logic [11:0] t, input logic p);
      return p ? (res < t) : (res >= t);
   endfunction
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      wrData <= d;
      wrEn <= 1'h1;
      @(posedge clk);
      wrEn <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      address <= a;
      rdEn <= 1'h1;
      @(posedge clk);
      rdEn <= 1'h0;
      #1 r = rdData;
   endtask
   task automatic waitDone();
      int n;
      n = 0;
      while (convDone !== 1'h1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      chk("done seen", convDone, 1);
      @(posedge clk);
      #1;
   endtask
   task automatic swConv(input logic [11:0] res);
      nextResult <= res;
      wr(OFS_CONV_CTRL, 8'h40);
      #1 chk("convStart", convStart, 1);
      rd(OFS_CONV_CTRL);
      chk("busy", r[CONV_START], 1);
      waitDone();
      rd(OFS_CONV_CTRL);
      chk("idle", r[CONV_START], 0);
   endtask
   task automatic trigCycles(input logic [8:0] d, output int n);
      // Delay changed only while the PWM lines are idle
      wr(OFS_DLY_LOW, d[7:0]);
      wr(OFS_CMP_CTRL, {7'h10, d[8]});
      s = starts;
      @(posedge clk);
      pwmCentre <= 1'h1;
      n = 0;
      // With a nonzero delay, a second centre pulse lands while the delay is pending
      while (convStart !== 1'h1 && n < 1000) begin
         @(posedge clk);
         pwmCentre <= (n == 3);
         n++;
         #1;
      end
      chk("trigger start", convStart, 1);
      @(posedge clk);
      pwmCentre <= 1'h1;
      @(posedge clk);
      pwmCentre <= 1'h0;
      waitDone();
      chk("starts", starts - s, 1);
   endtask
   task automatic endOfTest();
      $display("checks %0d, mismatches %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #2000000;
      numErrors++;
      endOfTest();
   end

   // =====================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      rd(OFS_CMP_CTRL);
      chk("ctrl reset", r, 8'h00);
      rd(OFS_DLY_LOW);
      chk("delay reset", r, 8'h00);
      wr(OFS_CMP_CTRL, 8'hFF);
      rd(OFS_CMP_CTRL);
      chk("ctrl rw", r, 8'hE1);
      wr(OFS_DLY_LOW, 8'hA5);
      rd(OFS_DLY_LOW);
      chk("delay rw", r, 8'hA5);
      rd(8'h10);
      chk("unmapped", r, 8'h00);
      $display("registers done");
      for (int i = 0; i < 16; i++) begin
         thr = $random(seed);
         pol = $random(seed);
         v = (i < 4) ? thr - 12'(i % 2) : 12'($random(seed));
         wr(OFS_THR_LOW, thr[7:0]);
         wr(OFS_THR_HIGH, {4'h0, thr[11:8]});
         wr(OFS_CMP_CTRL, {1'h1, pol, 6'h20});
         wr(OFS_PWM_RUN, 8'h01);
         #1 chk("run restart", pwm_run_a, 1);
         b = brakes;
         swConv(v);
         rd(OFS_CMP_CTRL);
         chk("compare", r[CMP_RESULT], cmpExp(v, thr, pol));
         chk("brakes", brakes - b, cmpExp(v, thr, pol));
         chk("run", pwm_run_a, !cmpExp(v, thr, pol));
      end
      $display("compare done");
      wr(OFS_THR_LOW, 8'h00);
      wr(OFS_THR_HIGH, 8'h00);
      wr(OFS_CMP_CTRL, 8'h80);
      b = brakes;
      swConv(12'hFFF);
      chk("disabled", brakes - b, 0);
      wr(OFS_CMP_CTRL, 8'h20);
      wr(OFS_PWM_RUN, 8'h01);
      swConv(12'h005);
      rd(OFS_CMP_CTRL);
      chk("compare", r[CMP_RESULT], 1);
      chk("no brake", brakes - b, 0);
      chk("run kept", pwm_run_a, 1);
      $display("brake gating done");
      rd(OFS_INT_STAT);
      chk("brake status", r[INT_BRAKE], brakes > 0);
      wr(OFS_INT_STAT, 8'h03);
      #1 chk("irq clear", irq, 0);
      wr(OFS_INT_MASK, 8'h01);
      swConv(12'h000);
      chk("irq", irq, 1);
      wr(OFS_INT_STAT, 8'h01);
      #1 chk("irq w1c", irq, 0);
      wr(OFS_INT_MASK, 8'h00);
      swConv(12'h000);
      chk("irq masked", irq, 0);
      rd(OFS_INT_STAT);
      chk("status", r[INT_DONE], 1);
      $display("interrupt done");
      wr(OFS_TRIG_CTRL, 8'h0A);
      trigCycles(9'h000, n0);
      trigCycles(9'h12C, n1);
      chk("delay", n1 - n0, 300);
      swConv(12'h000);
      $display("delay done");
      wr(OFS_DLY_LOW, 8'h00);
      wr(OFS_CMP_CTRL, 8'h20);
      // Each case first makes a condition that must not fire, then the selected one
      for (int k = 0; k < 5; k++) begin
         lv = (k == 1) ? 4'hF : 4'h0;
         // New selection first, so the level change is never its own edge
         wr(OFS_TRIG_CTRL, cfg[k]);
         {pin, pwmChannel} <= lv;
         s = starts;
         repeat (6) @(posedge clk);
         lv[(k + 1) % 4] = ~lv[(k + 1) % 4];
         {pin, pwmChannel} <= lv;
         pwmCentre <= (k == 4);
         @(posedge clk);
         pwmCentre <= 1'h0;
         repeat (6) @(posedge clk);
         lv[k % 4] = ~lv[k % 4];
         {pin, pwmChannel} <= lv;
         pwmEnd <= (k == 4);
         @(posedge clk);
         pwmEnd <= 1'h0;
         waitDone();
         chk("trigger", starts - s, 1);
      end
      $display("trigger select done");
      endOfTest();
   end
endmodule
